// ---- shared/ddr_cmd_pkg.sv ----
package ddr_cmd_pkg;
   // Widths of the module's command and data paths
   localparam int ROW_W = 13;
   localparam int COL_W = 10;
   localparam int BANKS = 4;
   localparam int BA_W = 2;
   localparam int DQ_W = 72;
   localparam int LANES = 9;
   // Address line that selects all banks or auto-precharge
   localparam int AP_BIT = 10;
   // Command codes as {ras_n, cas_n, we_n}
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   localparam logic [2:0] CMD_READ = 3'h5;
   localparam logic [2:0] CMD_NOP = 3'h7;
   // Burst beats, one beat per clock in this model
   localparam logic [2:0] BURST_BEATS = 3'h4;
   // Cycles after a write command that strobe edges are accepted
   localparam logic [2:0] WR_WIN_CYC = 3'h7;
   // Reset values
   localparam logic [BANKS-1:0] BANK_OPEN_RST = 4'h0;
   localparam logic [ROW_W-1:0] ROW_RST = 13'h0000;
   // Power state of the module
   typedef enum logic [1:0] {PWR_ACTIVE, PWR_DOWN, PWR_SELF} pwr_e;
endpackage

// ---- hdl/ddr_cmd_dev.sv ----
// Operation
// - Command inputs sampled on rising clock
// - Write data captured on strobe edges
// - Chip select high ignores commands only
// - Activate takes thirteen-bit row address
// - Read or write takes ten-bit start column
// - Precharge closes all or selected bank
// - Line ten selects auto-precharge on access
// - Two bank inputs decode to four banks
// - Clock enable low enters low power states
// - Module drives strobe during reads only
// - Masked write bytes reach wr_data with lane enable low
module ddr_cmd_dev (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic cke,
   input wire logic [ddr_cmd_pkg::ROW_W-1:0] addr,
   input wire logic [ddr_cmd_pkg::BA_W-1:0] ba,
   input wire logic [ddr_cmd_pkg::DQ_W-1:0] dq_i,
   output logic [ddr_cmd_pkg::DQ_W-1:0] dq_o,
   output logic dq_oe,
   input wire logic [ddr_cmd_pkg::LANES-1:0] dm,
   input wire logic dqs_i,
   output logic dqs_o,
   output logic dqs_oe,
   input wire logic [ddr_cmd_pkg::DQ_W-1:0] rd_data,
   output logic [ddr_cmd_pkg::BANKS-1:0] bank_open,
   output logic [ddr_cmd_pkg::BA_W-1:0] burst_bank,
   output logic [ddr_cmd_pkg::ROW_W-1:0] burst_row,
   output logic [ddr_cmd_pkg::COL_W-1:0] column_address_bits,
   output logic auto_precharge_select,
   output logic act_pulse,
   output logic rd_pulse,
   output logic wr_pulse,
   output logic ref_pulse,
   output logic power_down,
   output logic self_refresh,
   output logic [ddr_cmd_pkg::DQ_W-1:0] wr_data,
   output logic [ddr_cmd_pkg::LANES-1:0] wr_lane_en,
   output logic wr_valid
);
   import ddr_cmd_pkg::*;

   // Command state
   pwr_e pwr_r, pwr_nxt;
   logic [BANKS-1:0] bank_open_r, bank_open_nxt;
   logic [ROW_W-1:0] row_r [BANKS]; // Open row per bank
   logic [ROW_W-1:0] row_nxt [BANKS];
   logic [BA_W-1:0] bank_r, bank_nxt;
   logic [ROW_W-1:0] burst_row_r, burst_row_nxt;
   logic [COL_W-1:0] col_r, col_nxt;
   logic ap_r, ap_nxt;
   logic [2:0] ap_cnt_r, ap_cnt_nxt; // Beats left before auto close
   logic act_r, act_nxt, rd_r, rd_nxt, wr_r, wr_nxt, ref_r, ref_nxt;
   logic [2:0] cmd; // Live {ras_n, cas_n, we_n}
   logic cmd_live; // Command accepted this edge

   assign cmd = {ras_n, cas_n, we_n};
   assign cmd_live = (pwr_r == PWR_ACTIVE) && cke && !cs_n;

   // Command decode; all inputs taken on the rising clock
   always_comb begin
      pwr_nxt = pwr_r;
      bank_open_nxt = bank_open_r;
      row_nxt = row_r;
      bank_nxt = bank_r;
      burst_row_nxt = burst_row_r;
      col_nxt = col_r;
      ap_nxt = ap_r;
      ap_cnt_nxt = ap_cnt_r;
      act_nxt = 1'b0;
      rd_nxt = 1'b0;
      wr_nxt = 1'b0;
      ref_nxt = 1'b0;
      // Auto-precharge closes the bank once the burst has run out
      if (ap_cnt_r != 3'h0) begin
         ap_cnt_nxt = ap_cnt_r - 3'h1;
         if (ap_cnt_r == 3'h1) begin
            bank_open_nxt[bank_r] = 1'b0;
         end
      end
      case (pwr_r)
         PWR_ACTIVE: begin
            if (!cke) begin
               // Refresh with clock enable low means self refresh
               if (!cs_n && cmd == CMD_REF) begin
                  pwr_nxt = PWR_SELF;
               end else begin
                  pwr_nxt = PWR_DOWN;
               end
            end else if (!cs_n) begin
               // Bank index: ba[0] is the low bit
               if (cmd == CMD_ACT) begin
                  bank_open_nxt[ba] = 1'b1;
                  row_nxt[ba] = addr;
                  act_nxt = 1'b1;
               end else if (cmd == CMD_READ || cmd == CMD_WRITE) begin
                  bank_nxt = ba;
                  burst_row_nxt = row_r[ba];
                  col_nxt = addr[COL_W-1:0];
                  ap_nxt = addr[AP_BIT];
                  ap_cnt_nxt = addr[AP_BIT] ? BURST_BEATS : 3'h0;
                  rd_nxt = (cmd == CMD_READ);
                  wr_nxt = (cmd == CMD_WRITE);
               end else if (cmd == CMD_PRE) begin
                  if (addr[AP_BIT]) begin
                     bank_open_nxt = BANK_OPEN_RST;
                  end else begin
                     bank_open_nxt[ba] = 1'b0;
                  end
               end else if (cmd == CMD_REF) begin
                  ref_nxt = 1'b1;
               end
            end
         end
         // Exit on the first edge that sees clock enable high
         PWR_DOWN, PWR_SELF: begin
            if (cke) begin
               pwr_nxt = PWR_ACTIVE;
            end
         end
         default: pwr_nxt = PWR_ACTIVE;
      endcase
   end

   // Command registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_r <= PWR_ACTIVE;
         bank_open_r <= BANK_OPEN_RST;
         for (int i = 0; i < BANKS; i++) begin
            row_r[i] <= ROW_RST;
         end
         bank_r <= 2'h0;
         burst_row_r <= ROW_RST;
         col_r <= 10'h000;
         ap_r <= 1'b0;
         ap_cnt_r <= 3'h0;
         act_r <= 1'b0;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         ref_r <= 1'b0;
      end else begin
         pwr_r <= pwr_nxt;
         bank_open_r <= bank_open_nxt;
         row_r <= row_nxt;
         bank_r <= bank_nxt;
         burst_row_r <= burst_row_nxt;
         col_r <= col_nxt;
         ap_r <= ap_nxt;
         ap_cnt_r <= ap_cnt_nxt;
         act_r <= act_nxt;
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         ref_r <= ref_nxt;
      end
   end

   // Write capture state; strobe is asynchronous, so it is synchronised
   // and data is delayed by the same two stages to stay aligned
   logic dqs_s1_r, dqs_s2_r, dqs_s3_r;
   logic [DQ_W-1:0] dq_s1_r, dq_s2_r;
   logic [LANES-1:0] dm_s1_r, dm_s2_r;
   logic [2:0] win_r, win_nxt; // Strobe acceptance window
   logic [DQ_W-1:0] wdat_r, wdat_nxt;
   logic [LANES-1:0] wen_r, wen_nxt;
   logic wval_r, wval_nxt;

   // Each strobe edge inside the window stores one beat
   always_comb begin
      win_nxt = (win_r != 3'h0) ? win_r - 3'h1 : 3'h0;
      wdat_nxt = wdat_r;
      wen_nxt = wen_r;
      wval_nxt = 1'b0;
      if (wr_r) begin
         win_nxt = WR_WIN_CYC;
      end
      if (win_r != 3'h0 && dqs_s2_r != dqs_s3_r) begin
         wdat_nxt = dq_s2_r;
         wen_nxt = ~dm_s2_r;
         wval_nxt = 1'b1;
      end
   end

   // Write capture registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dqs_s1_r <= 1'b0;
         dqs_s2_r <= 1'b0;
         dqs_s3_r <= 1'b0;
         dq_s1_r <= '0;
         dq_s2_r <= '0;
         dm_s1_r <= '0;
         dm_s2_r <= '0;
         win_r <= 3'h0;
         wdat_r <= '0;
         wen_r <= '0;
         wval_r <= 1'b0;
      end else begin
         dqs_s1_r <= dqs_i;
         dqs_s2_r <= dqs_s1_r;
         dqs_s3_r <= dqs_s2_r;
         dq_s1_r <= dq_i;
         dq_s2_r <= dq_s1_r;
         dm_s1_r <= dm;
         dm_s2_r <= dm_s1_r;
         win_r <= win_nxt;
         wdat_r <= wdat_nxt;
         wen_r <= wen_nxt;
         wval_r <= wval_nxt;
      end
   end

   // Read strobe state
   logic [2:0] rcnt_r, rcnt_nxt; // Beats left in the read burst
   logic dqs_o_r, dqs_o_nxt;
   logic [DQ_W-1:0] dq_o_r, dq_o_nxt;

   // Module drives the strobe only while a read burst runs
   always_comb begin
      rcnt_nxt = (rcnt_r != 3'h0) ? rcnt_r - 3'h1 : 3'h0;
      dqs_o_nxt = (rcnt_r != 3'h0) ? ~dqs_o_r : 1'b0;
      dq_o_nxt = dq_o_r;
      if (rd_r) begin
         rcnt_nxt = BURST_BEATS;
         dqs_o_nxt = 1'b0;
      end
      // Load from the read command on, so the first beat is valid
      if (rd_r || rcnt_r != 3'h0) begin
         dq_o_nxt = rd_data;
      end
   end

   // Read registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rcnt_r <= 3'h0;
         dqs_o_r <= 1'b0;
         dq_o_r <= '0;
      end else begin
         rcnt_r <= rcnt_nxt;
         dqs_o_r <= dqs_o_nxt;
         dq_o_r <= dq_o_nxt;
      end
   end

   // Outputs
   assign dqs_oe = (rcnt_r != 3'h0);
   assign dq_oe = dqs_oe;
   assign dqs_o = dqs_o_r;
   assign dq_o = dq_o_r;
   assign bank_open = bank_open_r;
   assign burst_bank = bank_r;
   assign burst_row = burst_row_r;
   assign column_address_bits = col_r;
   assign auto_precharge_select = ap_r;
   assign act_pulse = act_r;
   assign rd_pulse = rd_r;
   assign wr_pulse = wr_r;
   assign ref_pulse = ref_r;
   assign power_down = (pwr_r == PWR_DOWN);
   assign self_refresh = (pwr_r == PWR_SELF);
   assign wr_data = wdat_r;
   assign wr_lane_en = wen_r;
   assign wr_valid = wval_r;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // Named steps of a read and of self refresh
   sequence s_read_cmd;
      cmd_live && cmd == CMD_READ;
   endsequence
   sequence s_self_entry;
      pwr_r == PWR_ACTIVE && !cke && !cs_n && cmd == CMD_REF;
   endsequence

   a_deselect_quiet: assert property (
      (pwr_r == PWR_ACTIVE && cs_n) |=> !(act_r || rd_r || wr_r || ref_r))
      else $error("command taken while deselected");
   a_row_latch: assert property (
      (cmd_live && cmd == CMD_ACT) |=> bank_open_r[$past(ba)]
         && row_r[$past(ba)] == $past(addr))
      else $error("activate row not stored");
   a_col_start: assert property (
      s_read_cmd |=> rd_r && col_r == $past(addr[COL_W-1:0]))
      else $error("start column wrong");
   a_pre_all: assert property (
      (cmd_live && cmd == CMD_PRE && addr[AP_BIT]) |=> bank_open_r == 4'h0)
      else $error("precharge all left a bank open");
   a_pre_one: assert property (
      (cmd_live && cmd == CMD_PRE && !addr[AP_BIT]) |=>
         !bank_open_r[$past(ba)])
      else $error("selected bank not closed");
   a_auto_close: assert property (
      (s_read_cmd ##0 addr[AP_BIT]) |=> ap_r ##4 !bank_open_r[bank_r])
      else $error("auto-precharge did not close bank");
   a_bank_map: assert property (
      (cmd_live && cmd == CMD_ACT && ba == 2'h1) |=> bank_open_r[1])
      else $error("bank inputs decoded wrongly");
   a_self_cycle: assert property (
      s_self_entry |=> self_refresh throughout (!cke [*1]) or
         (self_refresh ##0 cke ##1 !self_refresh))
      else $error("self refresh entry failed");
   a_pwr_exit: assert property (
      (pwr_r != PWR_ACTIVE && cke) |=> pwr_r == PWR_ACTIVE)
      else $error("power state not left on clock enable");
   a_read_strobe: assert property (
      s_read_cmd |=> !dqs_oe ##1 dqs_oe [*4] ##1 !dqs_oe)
      else $error("read strobe window wrong");
   a_read_data: assert property (
      dqs_oe |-> dq_o_r == $past(rd_data))
      else $error("read data not driven with strobe");
   a_mask_drop: assert property (
      wval_r |-> wen_r == ~$past(dm_s2_r))
      else $error("masked byte enabled");
   a_strobe_capture: assert property (
      (win_r != 3'h0 && dqs_s2_r != dqs_s3_r) |=> wval_r
         && wdat_r == $past(dq_s2_r))
      else $error("write beat not captured on strobe edge");
endmodule

// ---- testbench/ddr_ctrl_model.sv ----
module ddr_ctrl_model (
   input wire logic core_clk,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic cke,
   output logic [ddr_cmd_pkg::ROW_W-1:0] addr,
   output logic [ddr_cmd_pkg::BA_W-1:0] ba,
   output logic [ddr_cmd_pkg::DQ_W-1:0] dq_i,
   output logic [ddr_cmd_pkg::LANES-1:0] dm,
   output logic dqs_i
);
   timeunit 1ns;
   timeprecision 1ps;
   import ddr_cmd_pkg::*;
   // Idle bus: deselected NOP, strobe parked low before any write
   initial begin
      cs_n = 1'b1;
      {ras_n, cas_n, we_n} = CMD_NOP;
      cke = 1'b1;
      addr = '0;
      ba = '0;
      dq_i = '0;
      dm = '0;
      dqs_i = 1'b0;
   end
   // One command for one edge, then a deselect edge; cke level kept
   task automatic cmd(input logic [2:0] code, input logic [BA_W-1:0] b,
         input logic [ROW_W-1:0] a, input logic sel, input logic ck);
      @(posedge core_clk);
      cs_n <= sel;
      {ras_n, cas_n, we_n} <= code;
      addr <= a;
      ba <= b;
      cke <= ck;
      @(posedge core_clk);
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n} <= CMD_NOP;
      // Deselected lines float; the inverse exposes late sampling
      addr <= ~a;
      ba <= ~b;
   endtask
   // Spacing in whole cycles; 25 ns covers each short ns limit
   task automatic gap(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Data settles a cycle ahead, so the strobe edge sits mid-data
   task automatic beat(input logic [DQ_W-1:0] d, input logic [LANES-1:0] m);
      @(posedge core_clk);
      dq_i <= d;
      dm <= m;
      @(posedge core_clk);
      dqs_i <= ~dqs_i;
      @(posedge core_clk);
      // Data leaves the bus one cycle after the strobe edge
      dq_i <= ~d;
      dm <= ~m;
   endtask
endmodule

// ---- testbench/ddr_module_command_timing_bench.sv ----
module ddr_module_command_timing_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import ddr_cmd_pkg::*;
   localparam logic [DQ_W-1:0] ARRAY_WORD = 72'hC3_5A96_0FF0_1234_ABCD;
   localparam logic [ROW_W-1:0] ROWV = 13'h15A0;
   logic core_clk, rst_n, cs_n, ras_n, cas_n, we_n, cke, dqs_i, dq_oe;
   logic dqs_o, dqs_oe, auto_precharge_select, act_pulse, rd_pulse;
   logic wr_pulse, ref_pulse, power_down, self_refresh, wr_valid;
   logic [ROW_W-1:0] addr, burst_row;
   logic [BA_W-1:0] ba, burst_bank;
   logic [DQ_W-1:0] dq_i, dq_o, wr_data;
   logic [LANES-1:0] dm, wr_lane_en;
   logic [BANKS-1:0] bank_open;
   logic [COL_W-1:0] column_address_bits;
   int errors, comparisons;
   // Array word is fixed so read data can be predicted
   ddr_cmd_dev uut (.core_clk, .rst_n, .cs_n, .ras_n, .cas_n, .we_n, .cke,
      .addr, .ba, .dq_i, .dq_o, .dq_oe, .dm, .dqs_i, .dqs_o, .dqs_oe,
      .rd_data(ARRAY_WORD), .bank_open, .burst_bank, .burst_row,
      .column_address_bits, .auto_precharge_select, .act_pulse, .rd_pulse,
      .wr_pulse, .ref_pulse, .power_down, .self_refresh, .wr_data,
      .wr_lane_en, .wr_valid);
   ddr_ctrl_model ctrl (.core_clk, .cs_n, .ras_n, .cas_n, .we_n, .cke,
      .addr, .ba, .dq_i, .dm, .dqs_i);
   // 40 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic chk(input string nm, input logic [DQ_W-1:0] e,
         input logic [DQ_W-1:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic test_done;
      if (errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Open all four banks, each with its own row
   task automatic t_activate;
      logic [BANKS-1:0] exp_open;
      exp_open = '0;
      for (int b = 0; b < BANKS; b++) begin
         ctrl.cmd(CMD_ACT, BA_W'(b), ROWV + ROW_W'(b), 1'b0, 1'b1);
         exp_open[b] = 1'b1;
         #1 chk("act_pulse", 1'b1, act_pulse);
         chk("bank_open", exp_open, bank_open);
      end
   endtask
   // Read burst: fields, strobe pattern, data and optional close
   task automatic t_read(input logic [BA_W-1:0] b, input logic [ROW_W-1:0] a,
         input logic [BANKS-1:0] exp_open);
      int n;
      n = 0;
      ctrl.cmd(CMD_READ, b, a, 1'b0, 1'b1);
      #1 chk("rd_pulse", 1'b1, rd_pulse);
      chk("column", a[COL_W-1:0], column_address_bits);
      chk("auto_pre", a[AP_BIT], auto_precharge_select);
      chk("burst_bank", b, burst_bank);
      chk("burst_row", ROWV + ROW_W'(b), burst_row);
      repeat (8) begin
         @(posedge core_clk);
         #1;
         if (dqs_oe === 1'b1) begin
            chk("dqs_o", n[0], dqs_o);
            chk("dq_o", ARRAY_WORD, dq_o);
            chk("dq_oe", 1'b1, dq_oe);
            n++;
         end
      end
      chk("beats", 4, n);
      chk("bank_open", exp_open, bank_open);
   endtask
   // Deselected activate must be ignored
   task automatic t_cs_high;
      ctrl.cmd(CMD_ACT, 2'h1, ROWV, 1'b1, 1'b1);
      #1 chk("act_pulse", 1'b0, act_pulse);
      chk("bank_open", 4'hD, bank_open);
   endtask
   // Single-bank then all-bank precharge
   task automatic t_pre;
      ctrl.cmd(CMD_PRE, 2'h2, 13'h0000, 1'b0, 1'b1);
      #1 chk("bank_open", 4'h9, bank_open);
      ctrl.cmd(CMD_PRE, 2'h0, 13'h0400, 1'b0, 1'b1);
      #1 chk("bank_open", 4'h0, bank_open);
      ctrl.gap(1);
   endtask
   // One masked write beat captured on a strobe edge
   task automatic t_write(input logic [DQ_W-1:0] d, input logic [LANES-1:0] m);
      logic seen;
      seen = 1'b0;
      ctrl.cmd(CMD_WRITE, 2'h3, 13'h0010, 1'b0, 1'b1);
      #1 chk("wr_pulse", 1'b1, wr_pulse);
      ctrl.beat(d, m);
      repeat (8) begin
         @(posedge core_clk);
         #1;
         if (wr_valid === 1'b1 && !seen) begin
            seen = 1'b1;
            chk("wr_data", d, wr_data);
            chk("wr_lane_en", LANES'(~m), wr_lane_en);
         end
      end
      chk("wr_valid", 1'b1, seen);
      if (!seen) test_done();
      ctrl.gap(1);
   endtask
   // Power down and self refresh entry, ignored command, exit
   task automatic t_power;
      ctrl.cmd(CMD_NOP, 2'h0, 13'h0000, 1'b1, 1'b0);
      #1 chk("power_down", 1'b1, power_down);
      ctrl.cmd(CMD_ACT, 2'h0, ROWV, 1'b0, 1'b0);
      #1 chk("act_pulse", 1'b0, act_pulse);
      ctrl.cmd(CMD_NOP, 2'h0, 13'h0000, 1'b1, 1'b1);
      #1 chk("power_down", 1'b0, power_down);
      ctrl.gap(1);
      ctrl.cmd(CMD_REF, 2'h0, 13'h0000, 1'b0, 1'b0);
      #1 chk("self_refresh", 1'b1, self_refresh);
      ctrl.cmd(CMD_NOP, 2'h0, 13'h0000, 1'b1, 1'b1);
      #1 chk("self_refresh", 1'b0, self_refresh);
      ctrl.gap(200);
      ctrl.cmd(CMD_REF, 2'h0, 13'h0000, 1'b0, 1'b1);
      #1 chk("ref_pulse", 1'b1, ref_pulse);
   endtask
   // Main sequence
   initial begin
      errors = 0;
      comparisons = 0;
      rst_n = 1'b0;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      t_activate;
      t_read(2'h1, 13'h1EAB, 4'hD);
      t_read(2'h2, 13'h0005, 4'hD);
      t_cs_high;
      t_pre;
      ctrl.cmd(CMD_ACT, 2'h3, ROWV + 13'h0003, 1'b0, 1'b1);
      t_write(72'h5A_0123_4567_89AB_CDEF, 9'h000);
      t_write(72'hA5_FEDC_BA98_7654_3210, 9'h1A5);
      t_power;
      test_done();
   end
endmodule
